// ### core/fbac_device.sv
`timescale 1ns/1ns
// bank mapping, control registers, debug mode and access permissions
module fbac_device
    import fbac_pkg::*;
(
    // single clock and pin reset
    input wire logic ref_clk,
    input wire logic resetn,
    // processor and debugger requests, mapped answers back
    fbac_if.device bus,
    // chip pins, taken as synchronous to ref_clk
    input wire logic mode_select_pin,   // low selects debug mode
    // encryption byte as the flash array presents it
    input wire logic encByte0,          // bit0 of flash byte 0x0400
    // power management requests from the rest of the chip
    input wire logic sleepReq,          // cpu asks to sleep
    input wire logic deepSleepReq,
    input wire logic sleeping,          // system currently asleep
    // reset sources that debug mode must swallow
    input wire logic porReq,            // power-on/brown-out reset request
    input wire logic wdtReq,            // watchdog overflow request
    // mode and gated power events
    output logic debugMode,
    output logic sleepGrant,
    output logic deepSleepGrant,
    output logic porReset,
    output logic wdtReset,
    // power recovery for a system asleep at debug entry
    output logic wakeEvent,             // one-cycle power recovery pulse
    // debug port limit and flash control
    output logic fastTck,               // test clock limit raised to pll rate
    output logic program_clock_select,
    output logic [7:0] ctrl0            // second control register, passed out
);
    // all state of the block in one word, registered in one place
    typedef struct packed {
        // bank field of the bank register
        logic [1:0] bank;
        // clock select bit of the first control register
        logic cksel;
        // second control register, stored whole
        logic [7:0] ctrl0;
        // encryption latch, loaded once per reset
        logic encLatched;
        logic encLoaded;
        // mode as seen one edge ago
        logic dbg;
        // raised debug port limit
        logic fast;
        // one-cycle wake pulse
        logic wake;
        // power gates
        logic sleepG;
        logic deepG;
        logic por;
        logic wdt;
        // mapped fetch
        logic [16:0] fAddr;
        logic fValid;
        // register read data and access answer
        logic [7:0] rdata;
        logic grant;
        logic deny;
    } fbac_state_t;

    fbac_state_t st, next_st;

    // flash size from its page layout; the 17-bit address covers it exactly
    localparam int FLASH_BYTES = FBAC_PAGES * FBAC_PAGE_BYTES;
    localparam int ADDR_BITS = $clog2(FLASH_BYTES);

    // bank register decode, shared by the write and read paths
    function automatic logic bank_hit(input logic [7:0] a);
        return a == FBAC_BANK_SFR;
    endfunction

    // program-space register decode, shared by both control registers
    function automatic logic code_hit(input logic wr, input logic [15:0] a,
                                      input logic [15:0] target);
        return wr && a == target;
    endfunction

    // permission lookup for one request
    function automatic logic permit(input logic dbgM, input logic enc,
                                    input logic [1:0] op, input logic [ADDR_BITS-1:0] a);
        // metering mode: encryption has no say, mass erase never allowed
        if (!dbgM) begin
            if (op == FBAC_OP_MASS) return 1'b0;
            // lowest region is read-only so boot code cannot be lost in the field
            if (a <= FBAC_META_RO_HI) return op == FBAC_OP_READ;
            return 1'b1;
        end
        // debug mode with the bit set: everything goes
        if (enc) return 1'b1;
        // debug mode, bit clear: mass erase anywhere, reads only in the top bank
        if (op == FBAC_OP_MASS) return 1'b1;
        return (a >= FBAC_DBG_RD_LO) && (op == FBAC_OP_READ);
    endfunction

    // next-state logic
    always_comb begin
        logic allowed; // permission for the request on the bus this cycle
        allowed = 1'b0;
        next_st = st;

        // encryption sampled once after reset release only
        // a later change of the byte waits for the next pin reset
        if (!st.encLoaded) begin
            next_st.encLatched = encByte0;
            next_st.encLoaded = 1'b1;
        end

        // mode follows the pin one edge later
        next_st.dbg = !mode_select_pin;
        // wake if asleep as debug begins
        next_st.wake = !mode_select_pin && !st.dbg && sleeping;

        // gates use the pin itself, so a mode change acts at the next edge
        // sleep is refused while debugging so the debugger keeps the core
        next_st.sleepG = sleepReq && mode_select_pin;
        next_st.deepG = deepSleepReq && mode_select_pin;

        // power-on and watchdog resets are swallowed while debugging
        next_st.por = porReq && mode_select_pin;
        next_st.wdt = wdtReq && mode_select_pin;

        // debugger clock limit commands
        // commands only count while debugging
        if (bus.dbgCmdValid && st.dbg) begin
            if (bus.dbgCmd == FBAC_CMD_FAST) next_st.fast = 1'b1;
            else if (bus.dbgCmd == FBAC_CMD_SLOW) next_st.fast = 1'b0;
        end
        // leaving debug drops back to the default limit
        if (!st.dbg) next_st.fast = 1'b0;

        // sfr bank register
        if (bus.sfrWrite && bank_hit(bus.sfrAddr)) begin
            // reserved upper bits are not stored, so they always read zero
            next_st.bank = bus.sfrWdata[1:0];
        end
        // read data is zero for every other address
        if (bus.sfrRead && bank_hit(bus.sfrAddr)) begin
            next_st.rdata = {6'h00, st.bank};
        end else begin
            next_st.rdata = 8'h00;
        end

        // program-space control registers
        // without the unlock bit the write is dropped whole
        if (code_hit(bus.codeWrite, bus.codeAddr, FBAC_CTRL1_ADDR) &&
            bus.codeWdata[FBAC_UNLOCK_BIT]) begin
            next_st.cksel = bus.codeWdata[FBAC_CKSEL_BIT];
        end
        // second register is only stored and passed out, no unlock needed
        if (code_hit(bus.codeWrite, bus.codeAddr, FBAC_CTRL0_ADDR)) begin
            next_st.ctrl0 = bus.codeWdata;
        end

        // fetch mapping
        // lower half never looks at the bank, so vectors stay put on a switch
        // valid follows the request one edge later
        next_st.fValid = bus.fetchValid;
        if (!bus.fetchAddr[15]) begin
            next_st.fAddr = {2'b00, bus.fetchAddr[14:0]};
        end else begin
            // undefined code 00 falls back to bank one so execution stays defined
            unique case (st.bank)
                2'b10: next_st.fAddr = {2'b10, bus.fetchAddr[14:0]};
                2'b11: next_st.fAddr = {2'b11, bus.fetchAddr[14:0]};
                default: next_st.fAddr = {2'b01, bus.fetchAddr[14:0]};
            endcase
        end

        // access permission answer, exactly one of the pair per request
        allowed = permit(st.dbg, st.encLatched, bus.accOp, bus.accAddr);
        next_st.grant = bus.accValid && allowed;
        next_st.deny = bus.accValid && !allowed;
    end

    // state register
    // one register for the whole state word, loaded with its reset values by the pin reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            // everything idle, encryption latch empty until the first edge
            st <= '0;
            // bank one in the upper window after reset
            st.bank <= FBAC_BANK_RESET[1:0];
            // clock select starts at the slow setting
            st.cksel <= FBAC_CTRL1_RESET[FBAC_CKSEL_BIT];
            st.ctrl0 <= FBAC_CTRL0_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign debugMode = st.dbg;
    assign sleepGrant = st.sleepG;
    assign deepSleepGrant = st.deepG;
    assign porReset = st.por;
    assign wdtReset = st.wdt;
    assign wakeEvent = st.wake;
    assign fastTck = st.fast;
    assign program_clock_select = st.cksel;
    assign ctrl0 = st.ctrl0;

    // answers back to the processor side
    assign bus.flashAddr = st.fAddr;
    assign bus.flashValid = st.fValid;
    assign bus.sfrRdata = st.rdata;
    assign bus.accGrant = st.grant;
    assign bus.accDeny = st.deny;
endmodule // fbac_device

// ### core/fbac_pkg.sv
package fbac_pkg;
    localparam logic [15:0] FBAC_CTRL0_ADDR = 16'h0401;
    localparam logic [15:0] FBAC_CTRL1_ADDR = 16'h0402;
    localparam logic [7:0] FBAC_BANK_SFR = 8'ha0;
    localparam logic [7:0] FBAC_BANK_RESET = 8'h01;
    localparam logic [7:0] FBAC_CTRL1_RESET = 8'h00;
    localparam logic [7:0] FBAC_CTRL0_RESET = 8'h00;
    localparam int FBAC_UNLOCK_BIT = 7;
    localparam int FBAC_CKSEL_BIT = 6;
    localparam logic [16:0] FBAC_ENC_ADDR = 17'h00400;
    localparam logic [16:0] FBAC_FACTORY_LO = 17'h00400;
    localparam logic [16:0] FBAC_FACTORY_HI = 17'h005ff;
    localparam logic [16:0] FBAC_META_RO_HI = 17'h003ff;
    localparam logic [16:0] FBAC_DBG_RD_LO = 17'h18000;
    localparam int FBAC_PAGES = 256;
    localparam int FBAC_PAGE_BYTES = 512;
    localparam logic [7:0] FBAC_CMD_FAST = 8'h22;
    localparam logic [7:0] FBAC_CMD_SLOW = 8'h23;
    // operation codes on the access request
    typedef enum logic [1:0] {
        FBAC_OP_READ = 2'h0,
        FBAC_OP_WRITE = 2'h1,
        FBAC_OP_PAGE = 2'h2,
        FBAC_OP_MASS = 2'h3
    } fbac_op_t;
endpackage

// ### core/fbac_if.sv
`timescale 1ns/1ns
// processor side of the bank logic
interface fbac_if;
    logic fetchValid;       // program fetch strobe
    logic [15:0] fetchAddr; // cpu program address
    logic sfrWrite;         // sfr write strobe
    logic sfrRead;          // sfr read strobe
    logic [7:0] sfrAddr;
    logic [7:0] sfrWdata;
    logic codeWrite;        // program-space write (control regs)
    logic [15:0] codeAddr;
    logic [7:0] codeWdata;
    logic accValid;         // flash access request
    logic [1:0] accOp;
    logic [16:0] accAddr;
    logic dbgCmdValid;      // debugger command strobe
    logic [7:0] dbgCmd;
    logic [16:0] flashAddr; // mapped flash address
    logic flashValid;
    logic [7:0] sfrRdata;
    logic accGrant;
    logic accDeny;
    modport device (input fetchValid, fetchAddr, sfrWrite, sfrRead, sfrAddr, sfrWdata,
        codeWrite, codeAddr, codeWdata, accValid, accOp, accAddr, dbgCmdValid, dbgCmd,
        output flashAddr, flashValid, sfrRdata, accGrant, accDeny);
    modport host (output fetchValid, fetchAddr, sfrWrite, sfrRead, sfrAddr, sfrWdata,
        codeWrite, codeAddr, codeWdata, accValid, accOp, accAddr, dbgCmdValid, dbgCmd,
        input flashAddr, flashValid, sfrRdata, accGrant, accDeny);
endinterface

// ### core/fbac_host.sv
`timescale 1ns/1ns
// processor/debugger end: registers user requests onto the interface
module fbac_host
    import fbac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    fbac_if.host bus,
    input wire logic uFetch,
    input wire logic [15:0] uFetchAddr,
    input wire logic uSfrWr,
    input wire logic uSfrRd,
    input wire logic [7:0] uSfrAddr,
    input wire logic [7:0] uSfrData,
    input wire logic uSetClock,         // write control register with new clock select
    input wire logic uClockFast,
    input wire logic uAcc,
    input wire logic [1:0] uAccOp,
    input wire logic [16:0] uAccAddr,
    input wire logic uCmd,
    input wire logic [7:0] uCmdCode,
    output logic [7:0] sfrData,
    output logic granted,
    output logic denied,
    output logic [16:0] mappedAddr
);
    typedef struct packed {
        logic fv; logic [15:0] fa;
        logic sw; logic sr; logic [7:0] sa; logic [7:0] sd;
        logic cw; logic [7:0] cd;
        logic av; logic [1:0] ao; logic [16:0] aa;
        logic dv; logic [7:0] dc;
        logic [7:0] rd; logic g; logic d; logic [16:0] ma;
    } fbac_host_t;

    fbac_host_t st, next_st;

    // request and answer capture
    always_comb begin
        next_st = st;
        next_st.fv = uFetch;
        next_st.fa = uFetchAddr;
        next_st.sw = uSfrWr;
        next_st.sr = uSfrRd;
        next_st.sa = uSfrAddr;
        next_st.sd = uSfrData;
        next_st.cw = uSetClock;
        // unlock set, reserved low bits kept zero
        next_st.cd = {1'b1, uClockFast, 6'h00};
        // never target the factory page with writes or page erase
        next_st.av = uAcc && !((uAccOp == FBAC_OP_WRITE || uAccOp == FBAC_OP_PAGE) &&
            uAccAddr >= FBAC_FACTORY_LO && uAccAddr <= FBAC_FACTORY_HI);
        next_st.ao = uAccOp;
        next_st.aa = uAccAddr;
        next_st.dv = uCmd && (uCmdCode == FBAC_CMD_FAST || uCmdCode == FBAC_CMD_SLOW);
        next_st.dc = uCmdCode;
        next_st.rd = bus.sfrRdata;
        next_st.g = bus.accGrant;
        next_st.d = bus.accDeny;
        if (bus.flashValid) next_st.ma = bus.flashAddr;
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) st <= '0;
        else st <= next_st;
    end

    assign bus.fetchValid = st.fv;
    assign bus.fetchAddr = st.fa;
    assign bus.sfrWrite = st.sw;
    assign bus.sfrRead = st.sr;
    assign bus.sfrAddr = st.sa;
    assign bus.sfrWdata = st.sd;
    assign bus.codeWrite = st.cw;
    assign bus.codeAddr = FBAC_CTRL1_ADDR;
    assign bus.codeWdata = st.cd;
    assign bus.accValid = st.av;
    assign bus.accOp = st.ao;
    assign bus.accAddr = st.aa;
    assign bus.dbgCmdValid = st.dv;
    assign bus.dbgCmd = st.dc;
    assign sfrData = st.rd;
    assign granted = st.g;
    assign denied = st.d;
    assign mappedAddr = st.ma;
endmodule // fbac_host

// ### verification/fbac_sva.sv
`timescale 1ns/1ns
// watches the wires between the two ends; only sees the interface and the mode pin
module fbac_sva (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic mode_select_pin,
    input wire logic fetchValid,
    input wire logic [15:0] fetchAddr,
    input wire logic flashValid,
    input wire logic [16:0] flashAddr,
    input wire logic sfrRead,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrRdata,
    input wire logic accValid,
    input wire logic [1:0] accOp,
    input wire logic [16:0] accAddr,
    input wire logic accGrant,
    input wire logic accDeny
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_common_map: assert property (
        fetchValid && !fetchAddr[15] |=> flashValid && flashAddr == {2'b00, $past(fetchAddr[14:0])})
        else $error("common window fetch mapped wrongly");
    a_bank_nonzero: assert property (
        fetchValid && fetchAddr[15] |=> flashValid && flashAddr[16:15] != 2'b00)
        else $error("upper window fetch landed in common area");
    a_bank_offset: assert property (
        fetchValid |=> flashAddr[14:0] == $past(fetchAddr[14:0])) else $error("bank offset lost");
    a_bank_rsvd: assert property (
        sfrRead && sfrAddr == 8'ha0 |=> sfrRdata[7:2] == 6'h00) else $error("bank reserved bits set");
    a_sfr_other: assert property (
        sfrRead && sfrAddr != 8'ha0 |=> sfrRdata == 8'h00) else $error("foreign sfr answered");
    a_acc_answer: assert property (
        accValid |=> accGrant != accDeny) else $error("access not answered exactly once");
    a_acc_quiet: assert property (
        !accValid |=> !accGrant && !accDeny) else $error("answer without request");
    a_meter_mass: assert property (
        accValid && accOp == 2'h3 && mode_select_pin && $past(mode_select_pin) |=> accDeny)
        else $error("mass erase granted in metering mode");
    a_meter_rom: assert property (
        accValid && accOp != 2'h0 && accAddr <= 17'h003ff && mode_select_pin
        && $past(mode_select_pin) |=> accDeny) else $error("low region not read-only");
endmodule // fbac_sva

// ### verification/tb_flash_bank_access_control.sv
`timescale 1ns/1ns
// two ends joined by the interface; bench drives host user side and device pins
module tb_flash_bank_access_control;
    import fbac_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0; // held low from time zero, never unknown
    logic mode_select_pin, encByte0, slp, rstReq, sleeping;
    logic uFetch, uSfrWr, uSfrRd, uSetClock, uClockFast, uAcc, uCmd;
    logic [15:0] uFetchAddr;
    logic [7:0] uSfrAddr, uSfrData, uCmdCode, sfrData, ctrl0;
    logic [1:0] uAccOp;
    logic [16:0] uAccAddr, mappedAddr;
    logic granted, denied, debugMode, sleepGrant, deepSleepGrant, porReset, wdtReset;
    logic wakeEvent, fastTck, program_clock_select;
    int n_mismatch = 0;
    int num_checks = 0;
    fbac_if fbac_if_inst ();
    fbac_device fbac_device_inst (.ref_clk(ref_clk), .resetn(resetn), .bus(fbac_if_inst.device),
        .mode_select_pin(mode_select_pin), .encByte0(encByte0), .sleepReq(slp),
        .deepSleepReq(slp), .sleeping(sleeping), .porReq(rstReq), .wdtReq(rstReq),
        .debugMode(debugMode), .sleepGrant(sleepGrant), .deepSleepGrant(deepSleepGrant),
        .porReset(porReset), .wdtReset(wdtReset), .wakeEvent(wakeEvent), .fastTck(fastTck),
        .program_clock_select(program_clock_select), .ctrl0(ctrl0));
    fbac_host fbac_host_inst (.ref_clk(ref_clk), .resetn(resetn), .bus(fbac_if_inst.host),
        .uFetch(uFetch), .uFetchAddr(uFetchAddr), .uSfrWr(uSfrWr), .uSfrRd(uSfrRd),
        .uSfrAddr(uSfrAddr), .uSfrData(uSfrData), .uSetClock(uSetClock),
        .uClockFast(uClockFast), .uAcc(uAcc), .uAccOp(uAccOp), .uAccAddr(uAccAddr),
        .uCmd(uCmd), .uCmdCode(uCmdCode), .sfrData(sfrData), .granted(granted),
        .denied(denied), .mappedAddr(mappedAddr));
    fbac_sva fbac_sva_inst (.ref_clk(ref_clk), .resetn(resetn), .mode_select_pin(mode_select_pin),
        .fetchValid(fbac_if_inst.fetchValid), .fetchAddr(fbac_if_inst.fetchAddr),
        .flashValid(fbac_if_inst.flashValid), .flashAddr(fbac_if_inst.flashAddr),
        .sfrRead(fbac_if_inst.sfrRead), .sfrAddr(fbac_if_inst.sfrAddr),
        .sfrRdata(fbac_if_inst.sfrRdata), .accValid(fbac_if_inst.accValid),
        .accOp(fbac_if_inst.accOp), .accAddr(fbac_if_inst.accAddr),
        .accGrant(fbac_if_inst.accGrant), .accDeny(fbac_if_inst.accDeny));
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // compare and count
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request pulses for one cycle; answer lands three edges later
    task automatic settle;
        @(negedge ref_clk);
        {uFetch, uSfrWr, uSfrRd, uSetClock, uAcc, uCmd} = 6'h00;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic do_reset;
        resetn = 1'b0;
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
    endtask
    task automatic sfr(input logic rd, input logic [7:0] a, input logic [7:0] d);
        uSfrRd = rd;
        uSfrWr = !rd;
        uSfrAddr = a;
        uSfrData = d;
        settle();
        if (rd) chk("sfrData", {9'h000, d}, {9'h000, sfrData});
    endtask
    task automatic fetch(input logic [15:0] a, input logic [16:0] exp);
        uFetch = 1'b1;
        uFetchAddr = a;
        settle();
        chk("mappedAddr", exp, mappedAddr);
    endtask
    task automatic acc(input logic [1:0] op, input logic [16:0] a, input logic g);
        uAcc = 1'b1;
        uAccOp = op;
        uAccAddr = a;
        settle();
        chk("granted/denied", {15'h0000, g, !g}, {15'h0000, granted, denied});
    endtask
    // clock select resets low and follows writes
    task automatic t_clock;
        chk("clock select", 17'h00000, {16'h0000, program_clock_select});
        for (int i = 1; i >= 0; i--) begin
            uSetClock = 1'b1;
            uClockFast = i[0];
            settle();
            chk("clock select", {16'h0000, i[0]}, {16'h0000, program_clock_select});
        end
        chk("ctrl0", 17'h00000, {9'h000, ctrl0});
    endtask
    // bank register and both windows, including the undefined 00 code
    task automatic t_bank;
        sfr(1'b1, 8'ha0, 8'h01);
        sfr(1'b0, 8'ha0, 8'hfe);
        sfr(1'b1, 8'ha0, 8'h02);
        sfr(1'b1, 8'h55, 8'h00);
        for (int b = 0; b < 4; b++) begin
            sfr(1'b0, 8'ha0, b[7:0]);
            fetch(16'h8123, {(b == 0) ? 2'b01 : b[1:0], 15'h0123});
            fetch(16'h1234, 17'h01234);
        end
    endtask
    // metering mode with the encryption bit clear; mass erase never allowed
    task automatic t_meter;
        acc(2'h3, 17'h08000, 1'b0);
        acc(2'h1, 17'h00100, 1'b0);
        acc(2'h0, 17'h00100, 1'b1);
        acc(2'h1, 17'h08000, 1'b1);
        acc(2'h2, 17'h1fe00, 1'b1);
        uAcc = 1'b1;
        uAccOp = 2'h1;
        uAccAddr = 17'h00500;
        settle();
        chk("factory page write", 17'h00000, {15'h0000, granted, denied});
        uCmd = 1'b1;
        uCmdCode = 8'h22;
        settle();
        chk("fastTck", 17'h00000, {16'h0000, fastTck});
    endtask
    // debug mode gates, tck commands, encryption latched at reset only
    task automatic t_debug;
        mode_select_pin = 1'b0;
        slp = 1'b1;
        rstReq = 1'b1;
        sleeping = 1'b1;
        @(negedge ref_clk);
        chk("wakeEvent", 17'h00001, {16'h0000, wakeEvent});
        @(negedge ref_clk);
        sleeping = 1'b0;
        chk("mode gates", 17'h00010, {11'h000, wakeEvent, debugMode, sleepGrant,
            deepSleepGrant, porReset, wdtReset});
        chk("fastTck", 17'h00000, {16'h0000, fastTck});
        // 0x24 is no limit command and must leave the raised limit alone
        for (int i = 0; i < 3; i++) begin
            uCmd = 1'b1;
            uCmdCode = (i == 2) ? 8'h23 : 8'h22 + {i[6:0], 1'b0};
            settle();
            chk("fastTck", {16'h0000, i != 2}, {16'h0000, fastTck});
        end
        acc(2'h0, 17'h00100, 1'b0);
        acc(2'h0, 17'h18000, 1'b1);
        acc(2'h1, 17'h18000, 1'b0);
        acc(2'h3, 17'h00100, 1'b1);
        encByte0 = 1'b1;
        acc(2'h0, 17'h00100, 1'b0);
        do_reset();
        acc(2'h1, 17'h00100, 1'b1);
        acc(2'h2, 17'h18000, 1'b1);
        mode_select_pin = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("mode gates", 17'h0000f, {12'h000, debugMode, sleepGrant, deepSleepGrant,
            porReset, wdtReset});
    endtask
    // verdict and end of run
    task automatic wrap_up;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {uFetch, uSfrWr, uSfrRd, uSetClock, uClockFast, uAcc, uCmd, encByte0, slp} = 9'h000;
        {uFetchAddr, uSfrAddr, uSfrData, uCmdCode, uAccOp, uAccAddr} = 59'h0;
        rstReq = 1'b0;
        sleeping = 1'b0;
        mode_select_pin = 1'b1;
        @(negedge ref_clk);
        do_reset();
        t_clock();
        t_bank();
        t_meter();
        t_debug();
        wrap_up();
    end
endmodule // tb_flash_bank_access_control
